//--- logic/terminal_packet_assembler.sv
// Terminal packet assembler: byte count, pacing, modes, carrier inhibit
//
// Contract
// - Emit packet when buffered byte count equals maximum payload length.
// - Maximum payload length of zero means 256 bytes.
// - Length limit applies in conversational and transparent modes.
// - Pacing timer always in transparent; conversational only if enabled.
// - Transparent mode treats send-packet character as data.
// - Timer stays stopped until a byte is buffered; no empty packets.
// - Idle pacing: release after silence of setting times 100 ms.
// - Periodic pacing: release every setting times 100 ms.
// - Shared inhibit without full duplex: either carrier blocks both ports.
// - Shared inhibit off: each port uses its own carrier.
// - Disconnect-return on: selected stream disconnect enters command mode.
// - Disconnect-return off: disconnect leaves mode unchanged.
// - Stay-in-command off: connect enters connect-target mode.
// - Stay-in-command on: remain in command mode after connect.
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module terminal_packet_assembler (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Terminal bytes
  input wire packet_assembler_pkg::byte_s term_byte_in,
  // Link events and stream selection
  input wire packet_assembler_pkg::link_event_s link_event_in,
  input wire logic [3:0] current_stream_in,
  // Carrier detect pins of the two radio ports
  input wire logic [1:0] carrier_detect_in,
  // Packet release and mode
  output packet_assembler_pkg::packet_s packet_out,
  output logic [1:0] tx_permit_out,
  output packet_assembler_pkg::op_mode_e mode_out
);
  import packet_assembler_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    config_s cfg;
    op_mode_e mode;
    logic [8:0] count;
    logic running;
    logic restart;
    packet_s packet;
    logic [1:0] cd_meta;
    logic [1:0] cd_sync;
    logic [1:0] tx_permit;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } core_state_s;

  core_state_s state_reg;
  core_state_s state_next;
  logic timer_expire;
  logic [8:0] limit;
  logic pacing_on;
  logic is_payload;
  logic [31:0] read_word;
  logic carrier_any;

  // Decoded events, one cycle each
  logic bus_req;
  logic bus_rd_req;
  logic bus_rd_data;
  logic bus_wr_data;

  logic byte_taken;
  logic flush_taken;
  logic at_limit;
  logic pace_release;
  logic disc_selected;
  logic connect_taken;

  // ****************************************************
  // Pacing timer
  // ****************************************************
  // Restart is registered, so the timer lags a byte by one cycle
  pacing_timer u_pacing_timer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(state_reg.running),
    .restart_in(state_reg.restart),
    .limit_in(state_reg.cfg.pacing_timer_setting),
    .expire_out(timer_expire)
  );

  // ****************************************************
  // Combinational helpers
  // ****************************************************
  always_comb begin
    limit = (state_reg.cfg.max_payload_length == 8'h00) ? 9'h100 :
      {1'b0, state_reg.cfg.max_payload_length};
    pacing_on = (state_reg.mode == MODE_TRANSPARENT) ||
      ((state_reg.mode == MODE_CONVERSE) && state_reg.cfg.conv_pacing_enable);
    // Send-packet char only special in converse, when enabled
    is_payload = !((state_reg.mode == MODE_CONVERSE) &&
      state_reg.cfg.send_char_enable &&
      (term_byte_in.data == state_reg.cfg.send_packet_char));
    carrier_any = |state_reg.cd_sync;
  end

  // ****************************************************
  // Event decode
  // ****************************************************
  always_comb begin
    bus_req = hsel_in && hready_in && htrans_in[1];
    bus_rd_req = bus_req && !hwrite_in;
    bus_rd_data = state_reg.ph_valid && !state_reg.ph_write;
    bus_wr_data = state_reg.ph_valid && state_reg.ph_write;

    byte_taken = term_byte_in.valid && is_payload;
    flush_taken = term_byte_in.valid && !is_payload;
    // Nine-bit sum, so a limit of 256 is reachable
    at_limit = (state_reg.count + 9'h001) == limit;
    pace_release = timer_expire && state_reg.running && pacing_on &&
      (state_reg.count != 9'h000);

    disc_selected = link_event_in.disconnect &&
      (link_event_in.stream == current_stream_in);
    connect_taken = link_event_in.connect &&
      (state_reg.mode == MODE_COMMAND);
  end

  // ****************************************************
  // Read mux
  // ****************************************************
  always_comb begin
    read_word = 32'h0000_0000;
    case (state_reg.ph_addr)
      CTRL_OFFSET: begin
        read_word[CTRL_LEN_LSB +: 8] = state_reg.cfg.max_payload_length;
        read_word[CTRL_CONV_PACE_BIT] = state_reg.cfg.conv_pacing_enable;
        read_word[CTRL_SHARED_BIT] = state_reg.cfg.shared_channel_inhibit;
        read_word[CTRL_FDX_BIT] = state_reg.cfg.full_duplex_setting;
        read_word[CTRL_DISC_RET_BIT] =
          state_reg.cfg.disconnect_return_setting;
        read_word[CTRL_STAY_CMD_BIT] = state_reg.cfg.stay_in_command_setting;
        read_word[CTRL_TARGET_BIT] =
          state_reg.cfg.connect_target_transparent;
        read_word[CTRL_SEND_CHAR_EN_BIT] = state_reg.cfg.send_char_enable;
      end
      PACING_OFFSET: begin
        read_word[PACING_VAL_LSB +: 8] = state_reg.cfg.pacing_timer_setting;
        read_word[PACING_EVERY_BIT] = state_reg.cfg.pacing_every;
      end
      CHAR_OFFSET: begin
        read_word[7:0] = state_reg.cfg.send_packet_char;
      end
      STATUS_OFFSET: begin
        read_word[STATUS_COUNT_LSB +: 9] = state_reg.count;
        read_word[STATUS_MODE_LSB +: 2] = state_reg.mode;
        read_word[STATUS_TX_OK_LSB +: 2] = state_reg.tx_permit;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    state_next.packet = '0;
    state_next.restart = 1'b0;

    // ****************************************************
    // Carrier inhibit
    // ****************************************************
    // Pins pass two flops before use
    state_next.cd_meta = carrier_detect_in;
    state_next.cd_sync = state_reg.cd_meta;

    // One carrier blocks both ports when shared and half duplex
    if (state_reg.cfg.shared_channel_inhibit &&
        !state_reg.cfg.full_duplex_setting) begin
      state_next.tx_permit = carrier_any ? 2'b00 : 2'b11;
    end else begin
      // Each port looks at its own carrier
      state_next.tx_permit = ~state_reg.cd_sync;
    end

    // ****************************************************
    // Mode control
    // ****************************************************
    // Connect checked after disconnect; it acts only in command mode, so in a data mode the disconnect wins
    if (disc_selected) begin
      // Only the selected stream returns to command
      if (state_reg.cfg.disconnect_return_setting) begin
        state_next.mode = MODE_COMMAND;
      end
    end
    if (connect_taken) begin
      if (!state_reg.cfg.stay_in_command_setting) begin
        state_next.mode = state_reg.cfg.connect_target_transparent ?
          MODE_TRANSPARENT : MODE_CONVERSE;
      end
    end

    // ****************************************************
    // Byte assembly
    // ****************************************************
    // Command mode bytes belong to the command parser elsewhere
    if (state_reg.mode != MODE_COMMAND) begin
      if (byte_taken) begin
        state_next.count = state_reg.count + 9'h001;
        state_next.running = pacing_on;
        // Idle mode restarts on each byte
        if (!state_reg.cfg.pacing_every || !state_reg.running) begin
          state_next.restart = 1'b1;
        end
        // Release at length limit in either data mode
        if (at_limit) begin
          state_next.packet.valid = 1'b1;
          state_next.packet.length = limit;
          state_next.count = '0;
          state_next.running = 1'b0;
        end
      end else if (flush_taken) begin
        // Send-packet char flushes in converse; never empty
        if (state_reg.count != 9'h000) begin
          state_next.packet.valid = 1'b1;
          state_next.packet.length = state_reg.count;
        end
        state_next.count = '0;
        state_next.running = 1'b0;
      end else if (pace_release) begin
        // Expiry releases what is buffered, idle or periodic
        state_next.packet.valid = 1'b1;
        state_next.packet.length = state_reg.count;
        state_next.count = '0;
        state_next.running = 1'b0;
      end
    end else begin
      // Leftover bytes dropped on entering command mode
      state_next.count = '0;
      state_next.running = 1'b0;
    end

    // ****************************************************
    // Register bus
    // ****************************************************
    // Writes need no wait state; reads take one, always OKAY
    if (bus_wr_data) begin
      case (state_reg.ph_addr)
        CTRL_OFFSET: begin
          state_next.cfg.max_payload_length = hwdata_in[CTRL_LEN_LSB +: 8];
          state_next.cfg.conv_pacing_enable = hwdata_in[CTRL_CONV_PACE_BIT];
          state_next.cfg.shared_channel_inhibit = hwdata_in[CTRL_SHARED_BIT];
          state_next.cfg.full_duplex_setting = hwdata_in[CTRL_FDX_BIT];
          state_next.cfg.disconnect_return_setting =
            hwdata_in[CTRL_DISC_RET_BIT];
          state_next.cfg.stay_in_command_setting =
            hwdata_in[CTRL_STAY_CMD_BIT];
          state_next.cfg.connect_target_transparent =
            hwdata_in[CTRL_TARGET_BIT];
          state_next.cfg.send_char_enable = hwdata_in[CTRL_SEND_CHAR_EN_BIT];
        end
        PACING_OFFSET: begin
          state_next.cfg.pacing_timer_setting =
            hwdata_in[PACING_VAL_LSB +: 8];
          state_next.cfg.pacing_every = hwdata_in[PACING_EVERY_BIT];
        end
        CHAR_OFFSET: begin
          state_next.cfg.send_packet_char = hwdata_in[7:0];
        end
        default: begin
          state_next.cfg = state_reg.cfg;
        end
      endcase
    end
    state_next.ph_valid = bus_req;
    state_next.ph_write = hwrite_in;
    state_next.ph_addr = {haddr_in[7:2], 2'b00};
    state_next.resp = 1'b0;
    // Read data comes from a flop, hence the single wait state
    if (bus_rd_req) begin
      state_next.rdata = 32'h0000_0000;
      state_next.ready = 1'b0;
    end else begin
      state_next.ready = 1'b1;
    end
    if (bus_rd_data) begin
      state_next.rdata = read_word;
      state_next.ready = 1'b1;
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.cfg.max_payload_length <= MAX_PAYLOAD_RESET;
      state_reg.cfg.pacing_timer_setting <= PACING_RESET;
      state_reg.cfg.send_packet_char <= SEND_CHAR_RESET;
      state_reg.cfg.disconnect_return_setting <= DISC_RETURN_RESET;
      state_reg.cfg.send_char_enable <= SEND_CHAR_EN_RESET;
      state_reg.tx_permit <= TX_PERMIT_RESET;
      state_reg.ready <= 1'b1;
      state_reg.mode <= MODE_COMMAND;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Every output is a state field, no logic after the flops
  assign hrdata_out = state_reg.rdata;
  assign hreadyout_out = state_reg.ready;
  assign hresp_out = state_reg.resp;

  assign packet_out = state_reg.packet;
  assign tx_permit_out = state_reg.tx_permit;
  assign mode_out = state_reg.mode;

endmodule : terminal_packet_assembler

//--- logic/packet_assembler_pkg.sv
// Package: constants and carriers for the terminal packet assembler
package packet_assembler_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PACING_UNIT_MS = 100;
  localparam int unsigned PACING_UNIT_CYCLES =
    (CLK_HZ / 1000) * PACING_UNIT_MS;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PACING_OFFSET = 8'h04;
  localparam logic [7:0] CHAR_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;

  // CTRL fields
  localparam int CTRL_LEN_LSB = 0;
  localparam int CTRL_CONV_PACE_BIT = 8;
  localparam int CTRL_SHARED_BIT = 9;
  localparam int CTRL_FDX_BIT = 10;
  localparam int CTRL_DISC_RET_BIT = 11;
  localparam int CTRL_STAY_CMD_BIT = 12;
  localparam int CTRL_TARGET_BIT = 13;
  localparam int CTRL_SEND_CHAR_EN_BIT = 14;
  // PACING fields
  localparam int PACING_VAL_LSB = 0;
  localparam int PACING_EVERY_BIT = 8;
  // STATUS fields
  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_MODE_LSB = 9;
  localparam int STATUS_TX_OK_LSB = 11;

  // Reset values
  localparam logic [7:0] MAX_PAYLOAD_RESET = 8'h80;
  localparam logic [7:0] PACING_RESET = 8'h0A;
  localparam logic [7:0] SEND_CHAR_RESET = 8'h0D;
  localparam logic DISC_RETURN_RESET = 1'b1;
  localparam logic SEND_CHAR_EN_RESET = 1'b1;
  localparam logic [1:0] TX_PERMIT_RESET = 2'b11;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_COMMAND = 2'b00,
    MODE_CONVERSE = 2'b01,
    MODE_TRANSPARENT = 2'b10
  } op_mode_e;

  typedef struct packed {
    logic [7:0] max_payload_length;
    logic conv_pacing_enable;
    logic shared_channel_inhibit;
    logic full_duplex_setting;
    logic disconnect_return_setting;
    logic stay_in_command_setting;
    logic connect_target_transparent;
    logic send_char_enable;
    logic [7:0] pacing_timer_setting;
    logic pacing_every;
    logic [7:0] send_packet_char;
  } config_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_s;

  typedef struct packed {
    logic valid;
    logic [8:0] length;
  } packet_s;

  typedef struct packed {
    logic connect;
    logic disconnect;
    logic [3:0] stream;
  } link_event_s;

endpackage : packet_assembler_pkg

//--- logic/pacing_timer.sv
// Pacing timer: counts 100 ms units up to the programmed setting
`timescale 1ns/100ps
module pacing_timer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [7:0] limit_in,
  output logic expire_out
);
  import packet_assembler_pkg::*;

  typedef struct packed {
    logic [22:0] prescale;
    logic [7:0] units;
    logic expire;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.expire = 1'b0;
    if (restart_in || !run_in) begin
      state_next.prescale = '0;
      state_next.units = '0;
    end else if (state_reg.prescale == 23'(PACING_UNIT_CYCLES - 1)) begin
      state_next.prescale = '0;
      // Setting of zero expires on the first unit, never stalls
      if (state_reg.units + 8'h01 >= limit_in) begin
        state_next.units = '0;
        state_next.expire = 1'b1;
      end else begin
        state_next.units = state_reg.units + 8'h01;
      end
    end else begin
      state_next.prescale = state_reg.prescale + 23'h00_0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expire_out = state_reg.expire;

endmodule : pacing_timer

//--- testbench/assembler_checker.sv
// Checker: port-level properties of the terminal packet assembler
`timescale 1ns/100ps
module assembler_checker (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire packet_assembler_pkg::link_event_s link_event_in,
  input wire logic [3:0] current_stream_in,
  input wire logic [1:0] carrier_detect_in,
  input wire packet_assembler_pkg::packet_s packet_out,
  input wire logic [1:0] tx_permit_out,
  input wire packet_assembler_pkg::op_mode_e mode_out
);
  import packet_assembler_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****************************************************
  // Helpers
  // ****************************************************
  // Synchroniser holds stale carrier just after reset
  logic [2:0] up_cnt_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  sequence rd_req_s;
    hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  endsequence
  sequence rd_ans_s;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  // ****************************************************
  // Properties
  // ****************************************************
  AST_READ_WAIT: assert property (rd_req_s |=> rd_ans_s)
    else $error("read answer timing wrong");
  AST_NO_EMPTY: assert property (packet_out.valid |->
    packet_out.length inside {[9'd1:9'd256]})
    else $error("packet length out of range");
  AST_CMD_NO_PKT: assert property (
    (mode_out == MODE_COMMAND) [*3] |-> !packet_out.valid)
    else $error("packet released in command mode");
  AST_QUIET_MODE: assert property (
    !link_event_in.connect && !link_event_in.disconnect |=> $stable(mode_out))
    else $error("mode changed without link event");
  AST_CONNECT_HELD: assert property (
    link_event_in.connect && !link_event_in.disconnect &&
    mode_out != MODE_COMMAND |=> $stable(mode_out))
    else $error("connect changed a data mode");
  AST_DISC_OTHER: assert property (link_event_in.disconnect &&
    !link_event_in.connect && link_event_in.stream != current_stream_in
    |=> $stable(mode_out))
    else $error("other stream disconnect changed mode");
  AST_DISC_SEL: assert property (
    link_event_in.disconnect && !link_event_in.connect
    |=> mode_out == MODE_COMMAND || $stable(mode_out))
    else $error("disconnect led to a data mode");
  AST_PERMIT_OWN: assert property (up_cnt_reg == 3'h7 |->
    (tx_permit_out & $past(carrier_detect_in, 3)) == 2'b00)
    else $error("port permitted despite own carrier");
  AST_PERMIT_CLEAR: assert property (up_cnt_reg == 3'h7 &&
    $past(carrier_detect_in, 3) == 2'b00 |-> tx_permit_out == 2'b11)
    else $error("port blocked with no carrier");
endmodule : assembler_checker

//--- testbench/term_host.sv
// Host terminal model: sends bytes to the assembler at chosen spacing
`timescale 1ns/100ps
module term_host (
  input wire logic clk_in,
  output packet_assembler_pkg::byte_s byte_out
);
  import packet_assembler_pkg::*;
  initial byte_out = '0;
  // Released data inverted so a stale byte never looks valid
  task automatic send_burst(input int n, input logic [7:0] d, input int gap);
    @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      byte_out <= '{valid: 1'b1, data: d};
      @(posedge clk_in);
      if (gap > 0) begin
        byte_out <= '{valid: 1'b0, data: ~d};
        repeat (gap) @(posedge clk_in);
      end
    end
    byte_out <= '{valid: 1'b0, data: ~d};
  endtask : send_burst
endmodule : term_host

//--- testbench/tb.sv
// Testbench top: register access, byte bursts, link events, carrier
`timescale 1ns/100ps
module tb;
  import packet_assembler_pkg::*;
  logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, carrier, tx_permit;
  logic [2:0] hsize;
  logic [3:0] cur_stream;
  logic [8:0] pkt_len = 9'h000;
  byte_s term_byte;
  link_event_s link_ev;
  packet_s pkt;
  op_mode_e mode;
  int err_count, checks;
  int pkt_cnt = 0;
  terminal_packet_assembler dut_u (.core_clk_in(core_clk),
    .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .term_byte_in(term_byte), .link_event_in(link_ev),
    .current_stream_in(cur_stream), .carrier_detect_in(carrier),
    .packet_out(pkt), .tx_permit_out(tx_permit), .mode_out(mode));
  term_host host_u (.clk_in(core_clk), .byte_out(term_byte));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (pkt.valid === 1'b1) begin
      pkt_cnt <= pkt_cnt + 1;
      pkt_len <= pkt.length;
    end
  end
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_pkt(input int n, input logic [8:0] len);
    repeat (3) @(posedge core_clk);
    chk("packet count", 32'(n), 32'(pkt_cnt));
    chk("packet length", 32'(len), 32'(pkt_len));
  endtask : chk_pkt
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    haddr <= 32'(a);
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic link(input logic c, input logic dc, input logic [3:0] s);
    @(posedge core_clk);
    link_ev <= '{connect: c, disconnect: dc, stream: s};
    @(posedge core_clk);
    link_ev <= '0;
    repeat (2) @(posedge core_clk);
  endtask : link
  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, htrans, hsize} = {1'b1, 1'b0, 2'b00, 3'h2};
    {haddr, hwdata} = 64'h0;
    {link_ev, cur_stream, carrier} = '0;
    {err_count, checks} = '0;
    cur_stream = 4'h1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("mode", 32'(MODE_COMMAND), 32'(mode));
    chk("tx permit", 32'h0000_0003, 32'(tx_permit));
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl", 32'h0000_4880, rd);
    bus(1'b0, PACING_OFFSET, 32'h0, rd);
    chk("pacing", 32'h0000_000A, rd);
    bus(1'b0, CHAR_OFFSET, 32'h0, rd);
    chk("send char", 32'h0000_000D, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0000_0000, rd);
    host_u.send_burst(3, 8'h41, 0);
    chk_pkt(0, 9'h000);
    bus(1'b1, CTRL_OFFSET, 32'h0000_4803, rd);
    link(1'b1, 1'b0, 4'h1);
    chk("mode", 32'(MODE_CONVERSE), 32'(mode));
    host_u.send_burst(2, 8'h41, 1);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'({2'b11, 2'b01, 9'd2}), rd);
    host_u.send_burst(1, 8'h42, 0);
    chk_pkt(1, 9'd3);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'({2'b11, 2'b01, 9'd0}), rd);
    host_u.send_burst(1, 8'h0D, 0);
    chk_pkt(1, 9'd3);
    host_u.send_burst(1, 8'h41, 0);
    host_u.send_burst(1, 8'h0D, 0);
    chk_pkt(2, 9'd1);
    bus(1'b1, CTRL_OFFSET, 32'h0000_0800, rd);
    host_u.send_burst(255, 8'h43, 0);
    chk_pkt(2, 9'd1);
    host_u.send_burst(1, 8'h43, 0);
    chk_pkt(3, 9'h100);
    link(1'b0, 1'b1, 4'h2);
    chk("mode", 32'(MODE_CONVERSE), 32'(mode));
    link(1'b0, 1'b1, 4'h1);
    chk("mode", 32'(MODE_COMMAND), 32'(mode));
    bus(1'b1, CTRL_OFFSET, 32'h0000_6802, rd);
    link(1'b1, 1'b0, 4'h1);
    chk("mode", 32'(MODE_TRANSPARENT), 32'(mode));
    host_u.send_burst(3, 8'h0D, 0);
    chk_pkt(4, 9'd2);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status", 32'({2'b11, 2'b10, 9'd1}), rd);
    bus(1'b1, CTRL_OFFSET, 32'h0000_2002, rd);
    link(1'b0, 1'b1, 4'h1);
    chk("mode", 32'(MODE_TRANSPARENT), 32'(mode));
    bus(1'b1, CTRL_OFFSET, 32'h0000_3802, rd);
    link(1'b0, 1'b1, 4'h1);
    chk("mode", 32'(MODE_COMMAND), 32'(mode));
    link(1'b1, 1'b0, 4'h1);
    chk("mode", 32'(MODE_COMMAND), 32'(mode));
    carrier <= 2'b01;
    repeat (5) @(posedge core_clk);
    chk("tx permit", 32'h0000_0002, 32'(tx_permit));
    bus(1'b1, CTRL_OFFSET, 32'h0000_3A02, rd);
    repeat (5) @(posedge core_clk);
    chk("tx permit", 32'h0000_0000, 32'(tx_permit));
    carrier <= 2'b00;
    repeat (5) @(posedge core_clk);
    chk("tx permit", 32'h0000_0003, 32'(tx_permit));
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl after reset", 32'h0000_4880, rd);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status after reset", 32'({2'b11, 2'b00, 9'd0}), rd);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    final_report();
  end
endmodule : tb
bind terminal_packet_assembler assembler_checker chk_u (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .link_event_in(link_event_in),
  .current_stream_in(current_stream_in),
  .carrier_detect_in(carrier_detect_in), .packet_out(packet_out),
  .tx_permit_out(tx_permit_out), .mode_out(mode_out));
